// ==== core/prio_pkg.sv ====
// package: register map, field layout and reset values of the priority block
// ****************************************************************************
// ****************************************************************************
package prio_pkg;

  // ****************************************************************************
  // register byte addresses
  // ****************************************************************************
  localparam logic [4:0] ADDR_STATUS  = 5'h00;
  localparam logic [4:0] ADDR_CORE    = 5'h04;
  localparam logic [4:0] ADDR_INTCTL  = 5'h08;
  localparam logic [4:0] ADDR_UARTPRI = 5'h0c;
  localparam logic [4:0] ADDR_PWMPRI  = 5'h10;

  // ****************************************************************************
  // field positions
  // ****************************************************************************
  localparam int LEVEL_LO_POS   = 5;
  localparam int LEVEL_EXT_POS  = 3;
  localparam int NEST_DIS_POS   = 15;
  localparam int ADDR_FLT_POS   = 3;
  localparam int STK_FLT_POS    = 2;
  localparam int OSC_FLT_POS    = 1;
  localparam int UART2_PRI_POS  = 8;
  localparam int UART1_PRI_POS  = 4;
  localparam int PWM6_PRI_POS   = 12;
  localparam int PWM5_PRI_POS   = 8;
  localparam int PWM4_PRI_POS   = 4;
  localparam int PWM3_PRI_POS   = 0;
  localparam int NUM_SRC        = 6;

  // ****************************************************************************
  // reset values, top cpu level and priority-off code
  // ****************************************************************************
  localparam logic [2:0] PRI_RESET   = 3'h4;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [2:0] LEVEL_TOP   = 3'h7;
  localparam logic [2:0] PRI_OFF     = 3'h0;

  // ****************************************************************************
  // carriers
  // ****************************************************************************
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic addr_fault;
    logic stack_fault;
    logic osc_fault;
  } trap_evt_t;

endpackage

// ==== core/prio_sync.sv ====
// three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
module prio_sync
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin side
  input  wire logic async_i,
  // synchronous side
  output logic      level_o
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  always_comb
  begin
    stage_d = {stage_q[1:0], async_i};
    level_d = level_q;
    // only the second and third stages are compared; the first feeds the second only
    if (stage_q[1] == stage_q[2])
    begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end
    else
    begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;

endmodule

// ==== core/cpu_priority_and_trap_status.sv ====
// top: cpu priority level, trap flags and per-source priorities
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module cpu_priority_and_trap_status
(
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // avalon-mm slave
  input  wire logic [4:0]      avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  input  wire logic [3:0]      avs_byteenable_i,
  output logic [31:0]          avs_readdata_o,
  output logic                 avs_waitrequest_o,
  output logic [1:0]           avs_response_o,
  // core side: level entry on exception or interrupt acceptance
  input  wire logic            level_load_i,
  input  wire logic [3:0]      level_value_i,
  // trap event pulses from core logic
  input  wire prio_pkg::trap_evt_t trap_evt_i,
  // oscillator monitor, asynchronous
  input  wire logic            osc_fail_async_i,
  // pending requests from sources: uart2, uart1, pwm6, pwm5, pwm4, pwm3
  input  wire logic [5:0]      src_pending_i,
  // to core
  output logic [3:0]           cpu_level_o,
  output logic                 user_irq_block_o,
  output logic [5:0]           src_present_o
);

  // ****************************************************************************
  // state
  // ****************************************************************************
  logic [2:0]  level_lo_q;
  logic [2:0]  level_lo_d;
  logic        level_ext_q;
  logic        level_ext_d;
  logic        nest_dis_q;
  logic        nest_dis_d;
  logic [2:0]  trap_q;
  logic [2:0]  trap_d;
  logic [2:0]  pri_q [prio_pkg::NUM_SRC];
  logic [2:0]  pri_d [prio_pkg::NUM_SRC];
  logic        ack_q;
  logic        ack_d;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  resp_q;
  logic [1:0]  resp_d;
  logic [3:0]  level_out_q;
  logic        block_q;
  logic [5:0]  present_q;
  logic [5:0]  present_d;
  logic        osc_fail_sync;
  logic        osc_fail_prev_q;
  prio_pkg::bus_req_t req;

  prio_sync u_osc_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (osc_fail_async_i),
    .level_o (osc_fail_sync)
  );

  // ****************************************************************************
  // helpers
  // ****************************************************************************
  // field position of source n inside its priority register
  function automatic int src_pos(input int n);
    case (n)
      0:       src_pos = prio_pkg::UART2_PRI_POS;
      1:       src_pos = prio_pkg::UART1_PRI_POS;
      2:       src_pos = prio_pkg::PWM6_PRI_POS;
      3:       src_pos = prio_pkg::PWM5_PRI_POS;
      4:       src_pos = prio_pkg::PWM4_PRI_POS;
      default: src_pos = prio_pkg::PWM3_PRI_POS;
    endcase
  endfunction

  // register address that holds source n
  function automatic logic [4:0] src_addr(input int n);
    src_addr = (n < 2) ? prio_pkg::ADDR_UARTPRI : prio_pkg::ADDR_PWMPRI;
  endfunction

  // byte lane enable covering a bit position
  function automatic logic lane_on(input logic [3:0] be, input int pos);
    lane_on = be[pos / 8];
  endfunction

  assign req.read      = avs_read_i;
  assign req.write     = avs_write_i;
  assign req.address   = avs_address_i;
  assign req.writedata = avs_writedata_i;

  logic        wr_go;
  logic        rd_go;
  logic        mapped;
  assign wr_go  = req.write && !ack_q;
  assign rd_go  = req.read && !ack_q;
  assign mapped = (req.address == prio_pkg::ADDR_STATUS)  ||
                  (req.address == prio_pkg::ADDR_CORE)    ||
                  (req.address == prio_pkg::ADDR_INTCTL)  ||
                  (req.address == prio_pkg::ADDR_UARTPRI) ||
                  (req.address == prio_pkg::ADDR_PWMPRI);

  // ****************************************************************************
  // cpu level and nesting control
  // ****************************************************************************
  always_comb
  begin
    level_lo_d  = level_lo_q;
    level_ext_d = level_ext_q;
    nest_dis_d  = nest_dis_q;
    if (wr_go && req.address == prio_pkg::ADDR_STATUS && !nest_dis_q &&
        lane_on(avs_byteenable_i, prio_pkg::LEVEL_LO_POS))
    begin
      level_lo_d = req.writedata[prio_pkg::LEVEL_LO_POS +: 3];
    end
    // software may only clear the extension bit
    if (wr_go && req.address == prio_pkg::ADDR_CORE &&
        lane_on(avs_byteenable_i, prio_pkg::LEVEL_EXT_POS) &&
        !req.writedata[prio_pkg::LEVEL_EXT_POS])
    begin
      level_ext_d = 1'b0;
    end
    if (wr_go && req.address == prio_pkg::ADDR_INTCTL &&
        lane_on(avs_byteenable_i, prio_pkg::NEST_DIS_POS))
    begin
      nest_dis_d = req.writedata[prio_pkg::NEST_DIS_POS];
    end
    // hardware entry wins over a same-cycle software write
    if (level_load_i)
    begin
      level_lo_d  = level_value_i[2:0];
      level_ext_d = level_value_i[3];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level_lo_q  <= prio_pkg::LEVEL_RESET;
      level_ext_q <= 1'b0;
      nest_dis_q  <= 1'b0;
    end
    else
    begin
      level_lo_q  <= level_lo_d;
      level_ext_q <= level_ext_d;
      nest_dis_q  <= nest_dis_d;
    end
  end

  // ****************************************************************************
  // sticky trap flags
  // ****************************************************************************
  logic [2:0] trap_set;
  assign trap_set = {trap_evt_i.addr_fault,
                     trap_evt_i.stack_fault,
                     trap_evt_i.osc_fault || (osc_fail_sync && !osc_fail_prev_q)};

  always_comb
  begin
    trap_d = trap_q;
    if (wr_go && req.address == prio_pkg::ADDR_INTCTL && avs_byteenable_i[0])
    begin
      trap_d = {req.writedata[prio_pkg::ADDR_FLT_POS],
                req.writedata[prio_pkg::STK_FLT_POS],
                req.writedata[prio_pkg::OSC_FLT_POS]};
    end
    // a fault in the clearing cycle is kept
    trap_d = trap_d | trap_set;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trap_q          <= 3'h0;
      osc_fail_prev_q <= 1'b0;
    end
    else
    begin
      trap_q          <= trap_d;
      osc_fail_prev_q <= osc_fail_sync;
    end
  end

  // ****************************************************************************
  // per-source priority fields
  // ****************************************************************************
  genvar g;
  generate
    for (g = 0; g < prio_pkg::NUM_SRC; g++)
    begin : g_pri
      always_comb
      begin
        pri_d[g] = pri_q[g];
        if (wr_go && req.address == src_addr(g) &&
            lane_on(avs_byteenable_i, src_pos(g)))
        begin
          pri_d[g] = req.writedata[src_pos(g) +: 3];
        end
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          pri_q[g] <= prio_pkg::PRI_RESET;
        end
        else
        begin
          pri_q[g] <= pri_d[g];
        end
      end
    end
  endgenerate

  // ****************************************************************************
  // interrupt gating toward the core
  // ****************************************************************************
  logic [3:0] cur_level;
  logic       block;
  assign cur_level = {level_ext_q, level_lo_q};
  assign block     = level_ext_q ||
                     (level_lo_q == prio_pkg::LEVEL_TOP);

  always_comb
  begin
    present_d = '0;
    for (int n = 0; n < prio_pkg::NUM_SRC; n++)
    begin
      // 000 never beats level 0, so a disabled source never shows
      present_d[n] = src_pending_i[n] && !block &&
                     (pri_q[n] != prio_pkg::PRI_OFF) &&
                     ({1'b0, pri_q[n]} > cur_level);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level_out_q <= 4'h0;
      block_q     <= 1'b0;
      present_q   <= 6'h00;
    end
    else
    begin
      level_out_q <= cur_level;
      block_q     <= block;
      present_q   <= present_d;
    end
  end

  // ****************************************************************************
  // avalon-mm answer: one wait cycle, then acknowledge
  // ****************************************************************************
  always_comb
  begin
    ack_d   = (req.read || req.write) && !ack_q;
    rdata_d = rdata_q;
    resp_d  = resp_q;
    if (rd_go || wr_go)
    begin
      rdata_d = 32'h0000_0000;
      resp_d  = mapped ? 2'h0 : 2'h2;
    end
    if (rd_go)
    begin
      case (req.address)
        prio_pkg::ADDR_STATUS:
        begin
          rdata_d[prio_pkg::LEVEL_LO_POS +: 3] = level_lo_q;
        end
        prio_pkg::ADDR_CORE:
        begin
          rdata_d[prio_pkg::LEVEL_EXT_POS] = level_ext_q;
        end
        prio_pkg::ADDR_INTCTL:
        begin
          rdata_d[prio_pkg::NEST_DIS_POS] = nest_dis_q;
          rdata_d[prio_pkg::ADDR_FLT_POS] = trap_q[2];
          rdata_d[prio_pkg::STK_FLT_POS]  = trap_q[1];
          rdata_d[prio_pkg::OSC_FLT_POS]  = trap_q[0];
        end
        prio_pkg::ADDR_UARTPRI:
        begin
          rdata_d[prio_pkg::UART2_PRI_POS +: 3] = pri_q[0];
          rdata_d[prio_pkg::UART1_PRI_POS +: 3] = pri_q[1];
        end
        prio_pkg::ADDR_PWMPRI:
        begin
          rdata_d[prio_pkg::PWM6_PRI_POS +: 3] = pri_q[2];
          rdata_d[prio_pkg::PWM5_PRI_POS +: 3] = pri_q[3];
          rdata_d[prio_pkg::PWM4_PRI_POS +: 3] = pri_q[4];
          rdata_d[prio_pkg::PWM3_PRI_POS +: 3] = pri_q[5];
        end
        default:
        begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_q   <= 1'b0;
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end
    else
    begin
      ack_q   <= ack_d;
      // own flop, so the pin carries no gate after the register
      wait_q  <= !ack_d;
      rdata_q <= rdata_d;
      resp_q  <= resp_d;
    end
  end

  // ****************************************************************************
  // outputs
  // ****************************************************************************
  assign avs_readdata_o    = rdata_q;
  assign avs_response_o    = resp_q;
  assign avs_waitrequest_o = wait_q;
  assign cpu_level_o       = level_out_q;
  assign user_irq_block_o  = block_q;
  assign src_present_o     = present_q;

endmodule

// ==== test/prio_chk.sv ====
// checker: bus timing, level, masking and trap flag properties
`timescale 1ns/10ps
module prio_chk
(
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // register bus
  input wire logic [4:0]          avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic [31:0]         avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire logic [31:0]         avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  input wire logic [1:0]          avs_response_o,
  // core and sources
  input wire logic                level_load_i,
  input wire logic [3:0]          level_value_i,
  input wire prio_pkg::trap_evt_t trap_evt_i,
  input wire logic                osc_fail_async_i,
  input wire logic [5:0]          src_pending_i,
  input wire logic [3:0]          cpu_level_o,
  input wire logic                user_irq_block_o,
  input wire logic [5:0]          src_present_o
);
  // ********************
  // implemented bits
  // ********************
  logic [31:0] impl_mask;
  always_comb
  begin
    case (avs_address_i)
      prio_pkg::ADDR_STATUS:  impl_mask = 32'h000000e0;
      prio_pkg::ADDR_CORE:    impl_mask = 32'h00000008;
      prio_pkg::ADDR_INTCTL:  impl_mask = 32'h0000800e;
      prio_pkg::ADDR_UARTPRI: impl_mask = 32'h00000770;
      prio_pkg::ADDR_PWMPRI:  impl_mask = 32'h00007777;
      default:                impl_mask = 32'h00000000;
    endcase
  end
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  sequence s_rd_ctl;
    s_rd_done ##0 (avs_address_i == prio_pkg::ADDR_INTCTL);
  endsequence
  AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest_o)
    else $error("waitrequest late");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_RD_MASK: assert property (s_rd_done |-> (avs_readdata_o & ~impl_mask) == 32'h0)
    else $error("unimplemented bits read nonzero");
  AST_RD_RESP: assert property (s_rd_done |->
    avs_response_o == ((impl_mask == 32'h0) ? 2'h2 : 2'h0))
    else $error("wrong read response");
  AST_LEVEL_LOAD: assert property (level_load_i |->
    ##2 cpu_level_o == $past(level_value_i, 2))
    else $error("entered level not shown");
  AST_BLOCK: assert property (user_irq_block_o ==
    (cpu_level_o[3] || cpu_level_o[2:0] == 3'h7))
    else $error("block flag disagrees with level");
  AST_PRESENT: assert property ((src_present_o != 6'h00) |-> !user_irq_block_o
    && cpu_level_o < 4'h7 && (src_present_o & ~$past(src_pending_i)) == 6'h00)
    else $error("source presented wrongly");
  AST_EXT_HW_ONLY: assert property ($rose(cpu_level_o[3]) |->
    $past(level_load_i, 2) && $past(level_value_i[3], 2))
    else $error("extension set without core entry");
  AST_LOW_CHANGE: assert property ($changed(cpu_level_o[2:0]) |->
    $past(level_load_i, 2) || $past(avs_write_i, 2))
    else $error("level changed without cause");
  // a read of the control word that completes three edges after a pulse must show the pulsed flags
  AST_TRAP_SET: assert property ((trap_evt_i != 3'h0) ##3 s_rd_ctl |->
    (avs_readdata_o[3:1] & $past(trap_evt_i, 3)) == $past(trap_evt_i, 3))
    else $error("trap flag not set");
endmodule

bind cpu_priority_and_trap_status prio_chk prio_chk_inst
(
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
  .level_load_i(level_load_i), .level_value_i(level_value_i), .trap_evt_i(trap_evt_i),
  .osc_fail_async_i(osc_fail_async_i), .src_pending_i(src_pending_i),
  .cpu_level_o(cpu_level_o), .user_irq_block_o(user_irq_block_o),
  .src_present_o(src_present_o)
);

// ==== test/core_src_model.sv ====
// model of the core and interrupt sources beside the priority block
`timescale 1ns/10ps
module core_src_model
(
  // clock
  input  wire logic           clk_i,
  // core and source side
  output logic                level_load_o,
  output logic [3:0]          level_value_o,
  output prio_pkg::trap_evt_t trap_evt_o,
  output logic                osc_fail_async_o,
  output logic [5:0]          src_pending_o
);
  initial
  begin
    level_load_o = 1'b0;
    level_value_o = 4'h0;
    trap_evt_o = 3'h0;
    osc_fail_async_o = 1'b0;
    src_pending_o = 6'h00;
  end
  // level value is only meaningful with the load pulse, so it is scrambled after
  task automatic enter_level(input logic [3:0] v);
    @(posedge clk_i);
    level_load_o <= 1'b1;
    level_value_o <= v;
    @(posedge clk_i);
    level_load_o <= 1'b0;
    level_value_o <= ~v;
  endtask
  task automatic pulse_trap(input prio_pkg::trap_evt_t t);
    @(posedge clk_i);
    trap_evt_o <= t;
    @(posedge clk_i);
    trap_evt_o <= 3'h0;
  endtask
  task automatic set_osc(input logic v);
    @(posedge clk_i);
    osc_fail_async_o <= v;
  endtask
  task automatic set_pending(input logic [5:0] p);
    @(posedge clk_i);
    src_pending_o <= p;
  endtask
endmodule

// ==== test/cpu_priority_and_trap_status_tb.sv ====
// testbench: register access, level, trap and source presentation checks
`timescale 1ns/10ps
module cpu_priority_and_trap_status_tb;
  localparam logic [4:0] A_ST = prio_pkg::ADDR_STATUS;
  localparam logic [4:0] A_CO = prio_pkg::ADDR_CORE;
  localparam logic [4:0] A_IC = prio_pkg::ADDR_INTCTL;
  localparam logic [4:0] A_UA = prio_pkg::ADDR_UARTPRI;
  localparam logic [4:0] A_PW = prio_pkg::ADDR_PWMPRI;
  logic                clk_i = 1'b0;
  logic                rst_i;
  logic [4:0]          avs_address_i;
  logic                avs_read_i;
  logic                avs_write_i;
  logic [31:0]         avs_writedata_i;
  logic [3:0]          avs_byteenable_i;
  logic [31:0]         avs_readdata_o;
  logic                avs_waitrequest_o;
  logic [1:0]          avs_response_o;
  logic                level_load_i;
  logic [3:0]          level_value_i;
  prio_pkg::trap_evt_t trap_evt_i;
  logic                osc_fail_async_i;
  logic [5:0]          src_pending_i;
  logic [3:0]          cpu_level_o;
  logic                user_irq_block_o;
  logic [5:0]          src_present_o;
  logic [31:0]         rd_data;
  logic [1:0]          rd_resp;
  int                  failures = 0;
  int                  check_count = 0;
  logic [4:0]          addr_tab [6] = '{A_ST, A_CO, A_IC, A_UA, A_PW, 5'h14};
  logic [31:0]         rst_tab [6] = '{32'h0, 32'h0, 32'h0, 32'h440, 32'h4444, 32'h0};

  always #20 clk_i = ~clk_i;

  cpu_priority_and_trap_status cpu_priority_and_trap_status_inst
  (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .level_load_i(level_load_i), .level_value_i(level_value_i), .trap_evt_i(trap_evt_i),
    .osc_fail_async_i(osc_fail_async_i), .src_pending_i(src_pending_i),
    .cpu_level_o(cpu_level_o), .user_irq_block_o(user_irq_block_o),
    .src_present_o(src_present_o)
  );
  core_src_model core_src_model_inst
  (
    .clk_i(clk_i), .level_load_o(level_load_i), .level_value_o(level_value_i),
    .trap_evt_o(trap_evt_i), .osc_fail_async_o(osc_fail_async_i),
    .src_pending_o(src_pending_i)
  );

  // ********************
  // tasks
  // ********************
  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one idle edge before each request keeps a release and a new raise apart
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk_i);
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 16);
    if (n >= 16)
    begin
      failures++;
      tally_and_finish();
    end
    else
    begin
      rd_data = avs_readdata_o;
      rd_resp = avs_response_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input string name, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(name, rd_data, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  // ********************
  // sequence
  // ********************
  initial
  begin
    rst_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd("reset value", addr_tab[i], rst_tab[i]);
    check("unmapped read resp", {30'h0, rd_resp}, 32'h2);
    bus(1'b1, A_PW, 32'h0000ffff, 4'h1);
    rd("pwm low lane", A_PW, 32'h00004477);
    wr(A_PW, 32'hffffffff);
    rd("pwm ones", A_PW, 32'h00007777);
    wr(A_UA, 32'hffffffff);
    rd("uart ones", A_UA, 32'h00000770);
    bus(1'b1, A_UA, 32'h0, 4'h2);
    rd("uart lane one", A_UA, 32'h00000070);
    wr(5'h14, 32'hffffffff);
    check("unmapped write resp", {30'h0, rd_resp}, 32'h2);
    wr(A_ST, 32'h000000e0);
    settle();
    check("level seven", {28'h0, cpu_level_o}, 32'h7);
    check("block seven", {31'h0, user_irq_block_o}, 32'h1);
    wr(A_IC, 32'h00008000);
    rd("nest disable", A_IC, 32'h00008000);
    wr(A_ST, 32'h00000020);
    rd("status locked", A_ST, 32'h000000e0);
    wr(A_IC, 32'h0);
    wr(A_ST, 32'hffffff7f);
    rd("status open", A_ST, 32'h00000060);
    wr(A_CO, 32'hffffffff);
    rd("ext not writable", A_CO, 32'h0);
    wr(A_PW, 32'h00000745);
    wr(A_UA, 32'h00000500);
    core_src_model_inst.set_pending(6'h3f);
    core_src_model_inst.enter_level(4'hc);
    settle();
    check("level twelve", {28'h0, cpu_level_o}, 32'hc);
    check("ext blocks", {26'h0, src_present_o}, 32'h0);
    rd("ext status", A_CO, 32'h8);
    rd("low field", A_ST, 32'h80);
    wr(A_CO, 32'h0);
    rd("ext cleared", A_CO, 32'h0);
    settle();
    check("present above four", {26'h0, src_present_o}, 32'h29);
    wr(A_ST, 32'h0);
    settle();
    check("present at zero", {26'h0, src_present_o}, 32'h39);
    core_src_model_inst.set_pending(6'h08);
    settle();
    check("present one", {26'h0, src_present_o}, 32'h08);
    wr(A_ST, 32'h000000e0);
    settle();
    check("present at seven", {26'h0, src_present_o}, 32'h0);
    core_src_model_inst.pulse_trap(3'b100);
    rd("address fault", A_IC, 32'h8);
    core_src_model_inst.pulse_trap(3'b010);
    rd("stack fault", A_IC, 32'hc);
    core_src_model_inst.set_osc(1'b1);
    repeat (8) @(posedge clk_i);
    rd("osc fault", A_IC, 32'he);
    wr(A_IC, 32'h0);
    rd("faults cleared", A_IC, 32'h0);
    core_src_model_inst.pulse_trap(3'b001);
    rd("osc event", A_IC, 32'h2);
    core_src_model_inst.set_osc(1'b0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("second reset", A_PW, 32'h4444);
    rd("traps after reset", A_IC, 32'h0);
    check("level after reset", {28'h0, cpu_level_o}, 32'h0);
    tally_and_finish();
  end
endmodule
